/* src/gsi_status_irq_unit.sv */
// graphics status, sticky interrupt flags, enables and work area 1 address
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module gsi_status_irq_unit
    import gsi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire gsi_unit_busy_type unit_busy_in,
    input wire gsi_blank_type blank_in,
    input wire logic cmd_push_in,
    input wire logic cmd_pop_in,
    output logic cmd_fifo_full_out,
    output logic cmd_fifo_empty_out,
    output logic cmd_accepted_out,
    output logic [23:0] work_area1_start_out,
    output logic irq_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        gsi_bus_state_type bus_state;
        logic waitrequest;
        logic [31:0] readdata;
        logic [15:0] irq_enable;
        logic [7:0] flags;
        logic [23:0] work_area1_start;
        logic [GSI_CNT_W-1:0] cmd_watermark_level;
        gsi_unit_busy_type busy_prev;
        logic full_prev;
        logic empty_prev;
        logic [GSI_CNT_W-1:0] count_prev;
        logic irq;
    } gsi_main_state_type;

    gsi_main_state_type state_reg;
    gsi_main_state_type state_next;

    logic [GSI_CNT_W-1:0] cmd_count;
    logic cmd_full;
    logic cmd_empty;
    logic cmd_accepted;

    // ****************************************
    // command fifo occupancy
    // ****************************************
    gsi_cmd_level u_cmd_level (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .push_in(cmd_push_in),
        .pop_in(cmd_pop_in),
        .count_out(cmd_count),
        .full_out(cmd_full),
        .empty_out(cmd_empty),
        .accepted_out(cmd_accepted)
    );

    // ****************************************
    // live status and events
    // ****************************************
    logic below_watermark;
    logic watermark_event;
    logic [15:0] status_word;
    logic [15:0] flags_word;
    logic [15:0] fifo_ctrl_word;
    logic [7:0] set_events;

    always_comb
    begin
        below_watermark = (state_reg.cmd_watermark_level != 5'h00)
            && (cmd_count < state_reg.cmd_watermark_level);
        watermark_event = (state_reg.cmd_watermark_level != 5'h00)
            && (state_reg.count_prev == state_reg.cmd_watermark_level)
            && (cmd_count == state_reg.cmd_watermark_level - 5'h01);

        status_word = 16'h0000;
        status_word[GSI_BIT_ANY_UNIT] = unit_busy_in.inflate | unit_busy_in.rect_copy
            | unit_busy_in.char_draw;
        status_word[GSI_BIT_INFLATE] = unit_busy_in.inflate;
        status_word[GSI_BIT_RECT_COPY] = unit_busy_in.rect_copy;
        status_word[GSI_BIT_CHAR] = unit_busy_in.char_draw;
        status_word[GSI_BIT_VBLANK] = blank_in.vblank;
        status_word[GSI_BIT_HBLANK] = blank_in.hblank;
        status_word[GSI_BIT_WATERMARK] = below_watermark;
        status_word[GSI_BIT_FIFO_FULL] = cmd_full;
        status_word[GSI_BIT_FIFO_EMPTY] = cmd_empty;

        set_events = 8'h00;
        set_events[GSI_BIT_INFLATE] = state_reg.busy_prev.inflate && !unit_busy_in.inflate;
        set_events[GSI_BIT_RECT_COPY] = state_reg.busy_prev.rect_copy && !unit_busy_in.rect_copy;
        set_events[GSI_BIT_CHAR] = state_reg.busy_prev.char_draw && !unit_busy_in.char_draw;
        set_events[GSI_BIT_VBLANK] = blank_in.vblank;
        set_events[GSI_BIT_HBLANK] = blank_in.hblank;
        set_events[GSI_BIT_WATERMARK] = watermark_event;
        set_events[GSI_BIT_FIFO_FULL] = cmd_full && !state_reg.full_prev;
        set_events[GSI_BIT_FIFO_EMPTY] = cmd_empty && !state_reg.empty_prev;

        flags_word = 16'h0000;
        flags_word[7:0] = state_reg.flags;
        flags_word[GSI_BIT_ANY_UNIT] = state_reg.flags[GSI_BIT_INFLATE]
            | state_reg.flags[GSI_BIT_RECT_COPY] | state_reg.flags[GSI_BIT_CHAR];

        fifo_ctrl_word = 16'h0000;
        fifo_ctrl_word[GSI_WMK_LSB +: GSI_CNT_W] = state_reg.cmd_watermark_level;
        fifo_ctrl_word[GSI_CNT_LSB +: GSI_CNT_W] = cmd_count;
    end

    // ****************************************
    // register read mux
    // ****************************************
    logic [15:0] read_word;

    always_comb
    begin
        if (avs_address_in == GSI_OFS_STATUS)
        begin
            read_word = status_word;
        end
        else if (avs_address_in == GSI_OFS_IRQ_ENABLE)
        begin
            read_word = state_reg.irq_enable;
        end
        else if (avs_address_in == GSI_OFS_IRQ_FLAGS)
        begin
            read_word = flags_word;
        end
        else if (avs_address_in == GSI_OFS_W1_LOW)
        begin
            read_word = state_reg.work_area1_start[15:0];
        end
        else if (avs_address_in == GSI_OFS_W1_HIGH)
        begin
            read_word = {8'h00, state_reg.work_area1_start[23:16]};
        end
        else if (avs_address_in == GSI_OFS_FIFO_CTRL)
        begin
            read_word = fifo_ctrl_word;
        end
        else
        begin
            read_word = 16'h0000;
        end
    end

    // ****************************************
    // byte-lane write mask
    // ****************************************
    logic [15:0] lane_mask;
    logic [15:0] wdata;
    logic write_take;

    always_comb
    begin
        lane_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
        wdata = avs_writedata_in[15:0];
        write_take = avs_write_in && (state_reg.bus_state == GSI_BUS_ACK);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [7:0] clear_bits;
        logic [15:0] flag_pending;
        clear_bits = 8'h00;
        flag_pending = 16'h0000;
        state_next = state_reg;

        // bus handshake: one wait cycle, answer in the next
        case (state_reg.bus_state)
            GSI_BUS_IDLE:
            begin
                if (avs_read_in || avs_write_in)
                begin
                    state_next.bus_state = GSI_BUS_ACK;
                    state_next.waitrequest = 1'b0;
                    state_next.readdata = avs_read_in ? {16'h0000, read_word} : GSI_RDATA_ZERO;
                end
            end
            GSI_BUS_ACK:
            begin
                state_next.bus_state = GSI_BUS_IDLE;
                state_next.waitrequest = 1'b1;
                state_next.readdata = GSI_RDATA_ZERO;
            end
            default:
            begin
                state_next.bus_state = GSI_BUS_IDLE;
                state_next.waitrequest = 1'b1;
            end
        endcase

        // register writes
        if (write_take)
        begin
            if (avs_address_in == GSI_OFS_IRQ_ENABLE)
            begin
                state_next.irq_enable = ((state_reg.irq_enable & ~lane_mask)
                    | (wdata & lane_mask)) & GSI_IE_MASK;
            end
            else if (avs_address_in == GSI_OFS_IRQ_FLAGS)
            begin
                clear_bits = lane_mask[7:0] & ~wdata[7:0];
            end
            else if (avs_address_in == GSI_OFS_W1_LOW)
            begin
                state_next.work_area1_start[15:0] = (state_reg.work_area1_start[15:0] & ~lane_mask)
                    | (wdata & lane_mask);
            end
            else if (avs_address_in == GSI_OFS_W1_HIGH)
            begin
                if (avs_byteenable_in[0])
                begin
                    state_next.work_area1_start[23:16] = wdata[7:0];
                end
            end
            else if (avs_address_in == GSI_OFS_FIFO_CTRL)
            begin
                if (avs_byteenable_in[1])
                begin
                    state_next.cmd_watermark_level = wdata[GSI_WMK_LSB +: GSI_CNT_W];
                end
            end
        end

        // sticky flags: a set in the clearing cycle wins
        state_next.flags = (state_reg.flags & ~clear_bits) | set_events;

        // edge history
        state_next.busy_prev = unit_busy_in;
        state_next.full_prev = cmd_full;
        state_next.empty_prev = cmd_empty;
        state_next.count_prev = cmd_count;

        // interrupt request from the next flag image
        flag_pending[7:0] = state_next.flags;
        flag_pending[GSI_BIT_ANY_UNIT] = state_next.flags[GSI_BIT_INFLATE]
            | state_next.flags[GSI_BIT_RECT_COPY] | state_next.flags[GSI_BIT_CHAR];
        state_next.irq = |(flag_pending & state_next.irq_enable);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_reg.bus_state <= GSI_BUS_IDLE;
            state_reg.waitrequest <= 1'b1;
            state_reg.readdata <= GSI_RDATA_ZERO;
            state_reg.irq_enable <= GSI_IE_RESET;
            state_reg.flags <= GSI_FLAG_RESET;
            state_reg.work_area1_start <= GSI_W1_RESET;
            state_reg.cmd_watermark_level <= GSI_WMK_RESET;
            state_reg.busy_prev <= '{inflate: 1'b0, rect_copy: 1'b0, char_draw: 1'b0};
            state_reg.full_prev <= 1'b0;
            state_reg.empty_prev <= 1'b1;
            state_reg.count_prev <= 5'h00;
            state_reg.irq <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avs_readdata_out = state_reg.readdata;
    assign avs_waitrequest_out = state_reg.waitrequest;
    assign work_area1_start_out = state_reg.work_area1_start;
    assign irq_out = state_reg.irq;
    assign cmd_fifo_full_out = cmd_full;
    assign cmd_fifo_empty_out = cmd_empty;
    assign cmd_accepted_out = cmd_accepted;

endmodule

/* src/gsi_pkg.sv */
// shared constants and types of the graphics status and interrupt unit
package gsi_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [4:0] GSI_OFS_STATUS = 5'h00;
    localparam logic [4:0] GSI_OFS_IRQ_ENABLE = 5'h04;
    localparam logic [4:0] GSI_OFS_IRQ_FLAGS = 5'h08;
    localparam logic [4:0] GSI_OFS_W1_LOW = 5'h0c;
    localparam logic [4:0] GSI_OFS_W1_HIGH = 5'h10;
    localparam logic [4:0] GSI_OFS_FIFO_CTRL = 5'h14;

    // ****************************************
    // field positions
    // ****************************************
    localparam int GSI_BIT_ANY_UNIT = 15;
    localparam int GSI_BIT_INFLATE = 7;
    localparam int GSI_BIT_RECT_COPY = 6;
    localparam int GSI_BIT_CHAR = 5;
    localparam int GSI_BIT_VBLANK = 4;
    localparam int GSI_BIT_HBLANK = 3;
    localparam int GSI_BIT_WATERMARK = 2;
    localparam int GSI_BIT_FIFO_FULL = 1;
    localparam int GSI_BIT_FIFO_EMPTY = 0;
    localparam int GSI_WMK_LSB = 8;
    localparam int GSI_CNT_LSB = 0;

    // ****************************************
    // widths, masks and reset values
    // ****************************************
    localparam int GSI_CNT_W = 5;
    localparam logic [4:0] GSI_FIFO_DEPTH = 5'h10;
    localparam logic [15:0] GSI_IE_MASK = 16'h80ff;
    localparam logic [15:0] GSI_IE_RESET = 16'h0000;
    localparam logic [7:0] GSI_FLAG_RESET = 8'h00;
    localparam logic [23:0] GSI_W1_RESET = 24'h000000;
    localparam logic [4:0] GSI_WMK_RESET = 5'h00;
    localparam logic [31:0] GSI_RDATA_ZERO = 32'h00000000;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic inflate;
        logic rect_copy;
        logic char_draw;
    } gsi_unit_busy_type;

    typedef struct packed {
        logic vblank;
        logic hblank;
    } gsi_blank_type;

    typedef enum logic [0:0] {
        GSI_BUS_IDLE = 1'b0,
        GSI_BUS_ACK = 1'b1
    } gsi_bus_state_type;

endpackage

/* src/gsi_cmd_level.sv */
// command fifo occupancy tracker with full, empty and push accepted indication
`timescale 1ns/1ps
module gsi_cmd_level
    import gsi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic pop_in,
    output logic [GSI_CNT_W-1:0] count_out,
    output logic full_out,
    output logic empty_out,
    output logic accepted_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [GSI_CNT_W-1:0] count;
        logic full;
        logic empty;
        logic accepted;
    } gsi_level_state_type;

    gsi_level_state_type state_reg;
    gsi_level_state_type state_next;

    // ****************************************
    // occupancy update
    // ****************************************
    always_comb
    begin
        logic do_push;
        logic do_pop;
        do_push = 1'b0;
        do_pop = 1'b0;
        state_next = state_reg;
        do_push = push_in && !state_reg.full;
        do_pop = pop_in && !state_reg.empty;
        if (do_push && !do_pop)
        begin
            state_next.count = state_reg.count + 5'h01;
        end
        else if (do_pop && !do_push)
        begin
            state_next.count = state_reg.count - 5'h01;
        end
        state_next.full = (state_next.count == GSI_FIFO_DEPTH);
        state_next.empty = (state_next.count == 5'h00);
        state_next.accepted = do_push;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= '{count: 5'h00, full: 1'b0, empty: 1'b1, accepted: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign count_out = state_reg.count;
    assign full_out = state_reg.full;
    assign empty_out = state_reg.empty;
    assign accepted_out = state_reg.accepted;

endmodule

/* dv/gsi_status_irq_unit_chk.sv */
// port checker for the graphics status and interrupt unit
`timescale 1ns/1ps
module gsi_status_irq_unit_chk
    import gsi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire gsi_unit_busy_type unit_busy_in,
    input wire gsi_blank_type blank_in,
    input wire logic cmd_push_in,
    input wire logic cmd_pop_in,
    input wire logic cmd_fifo_full_out,
    input wire logic cmd_fifo_empty_out,
    input wire logic cmd_accepted_out,
    input wire logic [23:0] work_area1_start_out,
    input wire logic irq_out
);
    // ****
    // bus handshake
    // ****
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_req_idle;
        (avs_read_in || avs_write_in) && avs_waitrequest_out && $past(avs_waitrequest_out);
    endsequence
    sequence s_answer;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    a_bus_answer: assert property (s_req_idle |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_rdata_idle: assert property (avs_waitrequest_out |-> avs_readdata_out == GSI_RDATA_ZERO)
        else $error("read data not zero while idle");
    a_rdata_upper: assert property (avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_work_write: assert property (!$stable(work_area1_start_out) |-> $past(avs_write_in
        && !avs_waitrequest_out && (avs_address_in == GSI_OFS_W1_LOW || avs_address_in == GSI_OFS_W1_HIGH)))
        else $error("work area changed without write");
    // ****
    // command level
    // ****
    a_accept_cause: assert property (cmd_accepted_out |-> $past(cmd_push_in) && !$past(cmd_fifo_full_out))
        else $error("accept without a taken push");
    a_full_discard: assert property (cmd_fifo_full_out && cmd_push_in && !cmd_pop_in
        |=> cmd_fifo_full_out && !cmd_accepted_out)
        else $error("push while full not discarded");
    a_full_empty: assert property (!(cmd_fifo_full_out && cmd_fifo_empty_out))
        else $error("full and empty together");
    a_empty_hold: assert property (cmd_fifo_empty_out && !cmd_push_in |=> cmd_fifo_empty_out)
        else $error("empty fell without push");
endmodule

bind gsi_status_irq_unit gsi_status_irq_unit_chk u_chk (.core_clk_in, .rst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .unit_busy_in, .blank_in, .cmd_push_in, .cmd_pop_in, .cmd_fifo_full_out, .cmd_fifo_empty_out,
    .cmd_accepted_out, .work_area1_start_out, .irq_out);

/* dv/testbench.sv */
// self-checking bench for the graphics status and interrupt unit
`timescale 1ns/1ps
module testbench
    import gsi_pkg::*;
;
    logic core_clk_in, rst_in, rd, wr, push, pop, wreq, full, empty, acc, irq;
    logic [4:0] adr;
    logic [31:0] wd, rdat, got;
    logic [3:0] be;
    logic [23:0] w1;
    gsi_unit_busy_type busy;
    gsi_blank_type blank;
    int err_count, samples_checked;
    int cyc = 0;

    gsi_status_irq_unit dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .unit_busy_in(busy), .blank_in(blank),
        .cmd_push_in(push), .cmd_pop_in(pop), .cmd_fifo_full_out(full), .cmd_fifo_empty_out(empty),
        .cmd_accepted_out(acc), .work_area1_start_out(w1), .irq_out(irq));

    initial
    begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            end_sim();
        end
    end

    // ****
    // tasks
    // ****
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    task check(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    end
    endtask

    task bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [1:0] b);
    begin
        adr <= a;
        wd <= {16'h0000, d};
        be <= {2'b00, b};
        wr <= w;
        rd <= ~w;
        do
        begin
            @(posedge core_clk_in);
        end
        while (wreq !== 1'b0);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk_in);
    end
    endtask

    task wrr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 2'b11);
    endtask

    task rchk(input logic [4:0] a, input logic [15:0] e, input string n);
    begin
        bus(1'b0, a, 16'h0000, 2'b00);
        check(n, {16'h0000, e}, got);
    end
    endtask

    task fifo_op(input logic p, input int n);
    begin
        push <= p;
        pop <= ~p;
        repeat (n) @(posedge core_clk_in);
        push <= 1'b0;
        pop <= 1'b0;
        @(posedge core_clk_in);
    end
    endtask

    task hold(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    // ****
    // tests
    // ****
    initial
    begin
        rst_in = 1'b1;
        {rd, wr, push, pop, adr, wd, be} = '0;
        busy = '0;
        blank = '0;
        err_count = 0;
        samples_checked = 0;
        hold(3);
        rst_in <= 1'b0;
        hold(1);
        rchk(GSI_OFS_STATUS, 16'h0001, "status");
        for (int i = 1; i < 7; i++)
            rchk(5'(i * 4), 16'h0000, "reset or unmapped");
        wrr(GSI_OFS_IRQ_ENABLE, 16'hffff);
        rchk(GSI_OFS_IRQ_ENABLE, 16'h80ff, "enable");
        wrr(GSI_OFS_STATUS, 16'hffff);
        rchk(GSI_OFS_STATUS, 16'h0001, "status");
        wrr(5'h18, 16'hffff);
        rchk(5'h18, 16'h0000, "unmapped");
        wrr(GSI_OFS_IRQ_ENABLE, 16'h0000);
        wrr(GSI_OFS_W1_LOW, 16'h1234);
        wrr(GSI_OFS_W1_HIGH, 16'hffab);
        rchk(GSI_OFS_W1_HIGH, 16'h00ab, "w1 high");
        check("w1 out", 32'h00ab1234, {8'h00, w1});
        bus(1'b1, GSI_OFS_W1_LOW, 16'h56ff, 2'b10);
        rchk(GSI_OFS_W1_LOW, 16'h5634, "w1 low");
        $display("test registers done");
        busy <= 3'b101;
        hold(2);
        rchk(GSI_OFS_STATUS, 16'h80a1, "status");
        busy <= 3'b010;
        hold(2);
        rchk(GSI_OFS_STATUS, 16'h8041, "status");
        rchk(GSI_OFS_IRQ_FLAGS, 16'h80a0, "flags");
        busy <= 3'b000;
        hold(2);
        rchk(GSI_OFS_IRQ_FLAGS, 16'h80e0, "flags");
        wrr(GSI_OFS_IRQ_ENABLE, 16'h8000);
        hold(1);
        check("irq", 32'h1, {31'h0, irq});
        wrr(GSI_OFS_IRQ_FLAGS, 16'h0000);
        hold(1);
        check("irq", 32'h0, {31'h0, irq});
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0000, "flags");
        $display("test units done");
        wrr(GSI_OFS_IRQ_ENABLE, 16'h0010);
        blank <= 2'b10;
        hold(2);
        rchk(GSI_OFS_STATUS, 16'h0011, "status");
        check("irq", 32'h1, {31'h0, irq});
        blank <= 2'b01;
        hold(2);
        rchk(GSI_OFS_STATUS, 16'h0009, "status");
        blank <= 2'b00;
        hold(1);
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0018, "flags");
        wrr(GSI_OFS_IRQ_FLAGS, 16'h0010);
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0010, "flags");
        wrr(GSI_OFS_IRQ_ENABLE, 16'h0008);
        hold(1);
        check("irq", 32'h0, {31'h0, irq});
        wrr(GSI_OFS_IRQ_FLAGS, 16'h0000);
        $display("test blanking done");
        wrr(GSI_OFS_FIFO_CTRL, 16'h0300);
        fifo_op(1'b1, 1);
        check("accepted", 32'h1, {31'h0, acc});
        check("empty", 32'h0, {31'h0, empty});
        fifo_op(1'b1, 15);
        check("full", 32'h1, {31'h0, full});
        fifo_op(1'b1, 1);
        check("accepted", 32'h0, {31'h0, acc});
        rchk(GSI_OFS_FIFO_CTRL, 16'h0310, "count");
        rchk(GSI_OFS_STATUS, 16'h0002, "status");
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0002, "flags");
        fifo_op(1'b0, 13);
        rchk(GSI_OFS_STATUS, 16'h0000, "status");
        fifo_op(1'b0, 1);
        rchk(GSI_OFS_STATUS, 16'h0004, "status");
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0006, "flags");
        fifo_op(1'b0, 2);
        check("empty", 32'h1, {31'h0, empty});
        rchk(GSI_OFS_STATUS, 16'h0005, "status");
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0007, "flags");
        wrr(GSI_OFS_FIFO_CTRL, 16'h0000);
        wrr(GSI_OFS_IRQ_FLAGS, 16'h0000);
        fifo_op(1'b1, 1);
        fifo_op(1'b0, 1);
        rchk(GSI_OFS_STATUS, 16'h0001, "status");
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0001, "flags");
        wrr(GSI_OFS_IRQ_ENABLE, 16'h0001);
        hold(1);
        check("irq", 32'h1, {31'h0, irq});
        $display("test fifo done");
        rst_in <= 1'b1;
        hold(2);
        rst_in <= 1'b0;
        hold(1);
        check("irq", 32'h0, {31'h0, irq});
        check("w1 out", 32'h0, {8'h00, w1});
        rchk(GSI_OFS_IRQ_FLAGS, 16'h0000, "flags");
        $display("test reset again done");
        end_sim();
    end
endmodule
